// *** hdl/bds_pkg.sv ***
// Purpose: shared constants and carrier types for the bridge driver serial control block
// Assumes: system clock at 100 MHz, serial frame of 16 bits sent lsb first
// Notes:   positions index the 16-bit control word and the two 16-bit status words
package bds_pkg;

  // frame and control word layout
  localparam int FRAME_BITS   = 16;
  localparam int CNT_W        = 5;
  localparam int NUM_SW       = 11;
  localparam int CTRL_SEL     = 0;
  localparam int CTRL_SW_LO   = 1;
  localparam int CTRL_SW_HI   = 11;
  localparam int CTRL_TA_LO   = 5;
  localparam int CTRL_TA_HI   = 6;
  localparam int CTRL_TB_LO   = 7;
  localparam int CTRL_TB_HI   = 8;
  localparam int CTRL_MON_LO  = 12;
  localparam int CTRL_MON_HI  = 13;
  localparam int CTRL_LOCKOUT = 14;
  localparam int CTRL_CLR     = 15;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // status word layout
  localparam int ST_FAULT  = 0;
  localparam int ST_SW_LO  = 1;
  localparam int ST_SW_HI  = 11;
  localparam int ST0_TWARN = 12;
  localparam int ST0_UV    = 13;
  localparam int ST0_OV    = 14;
  localparam int ST1_TSD   = 12;
  localparam int ST_ONE    = 15;
  localparam logic [15:0] ST_RST = 16'h0000;

  // switches with a split (two bond wire) stage: legs a and b, heater
  localparam logic [10:0] SPLIT_MASK = 11'h40F;

  // filter times
  localparam int SYS_CLK_MHZ = 100;
  localparam int OL_FILT_US  = 500;
  localparam int OC_FILT_US  = 10;
  localparam int OL_FILT_CYC = OL_FILT_US * SYS_CLK_MHZ;
  localparam int OC_FILT_CYC = OC_FILT_US * SYS_CLK_MHZ;
  localparam int OL_CNT_W    = 17;
  localparam int OC_CNT_W    = 11;

  // raw analog comparator conditions, asynchronous to every clock
  typedef struct packed {
    logic        uv;
    logic        ov;
    logic        tsd;
    logic        twarn;
    logic [10:0] ol;
    logic [10:0] oc;
  } bds_cond_type;

  // gate drive and mode outputs, switch index 0 is control bit 1
  typedef struct packed {
    logic [10:0] stage_a;
    logic [10:0] stage_b;
    logic        standby;
    logic [1:0]  mon_sel;
  } bds_drive_type;

endpackage

// *** hdl/bds_serial_ctrl.sv ***
// Purpose: serial control and diagnostic front end of a multi-output bridge driver
// Assumes: chip select low at least 40 ns before the first serial clock rising edge
// Notes:   serial clock logic stops between frames; the system clock finishes each frame
//
// Contract
// [RL1] serial clock may idle low or high; sample on rise, shift out on fall
// [RL2] frames travel least significant bit first both ways
// [RL3] serial_out undriven while chip_select_n high, driven while low
// [RL4] after chip_select_n falls, serial_out shows the combined fault flag
// [RL5] each rising serial clock edge shifts serial_in into a 16-bit register
// [RL6] rising chip_select_n copies the shift register into the control register
// [RL7] bit counter cleared per frame; only the first 16 bits kept
// [RL8] first rising edge loads status word chosen by incoming bit 0
// [RL9] each later falling edge presents the next status bit
// [RL10] bit 0 low picks status word zero, high picks status word one
// [RL11] control bits 1 to 11 switch individual high or low side transistors
// [RL12] bits 1,2 drive leg a low/high side; bits 3,4 leg b
// [RL13] bits 12,13 both zero mean standby, else monitor source select
// [RL14] lockout bit set: supply fault disables outputs until status cleared
// [RL15] lockout bit clear: outputs return by themselves when supply recovers
// [RL16] frame with bit 15 set clears both status words at frame end
// [RL17] two status words; bit 0 of each is the combined fault flag
// [RL18] overcurrent bit disables its output until the host clears it
// [RL19] thermal shutdown bit turns all outputs off until cleared
// [RL20] open load must persist the filter time before its bit sets
// [RL21] overcurrent must persist the filter time before the output switches off
// [RL22] bits 5,6 high enable only stage a; bits 7,8 only stage b
// [RL23] bits 5 to 8 all high activate no split stage
// [RL24] other bit 5 to 8 combinations act normally; no shoot-through
// [RL25] test mode: serial_out shows serial clock OR serial_in
module bds_serial_ctrl #(
  parameter int OL_FILT_CYC_P = bds_pkg::OL_FILT_CYC
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   spi_clk_i,
  input  wire logic                   chip_select_n_i,
  input  wire logic                   serial_in_i,
  input  wire logic                   test_mode_i,
  input  wire bds_pkg::bds_cond_type  cond_i,
  output logic                        serial_out_o,
  output logic                        serial_out_oe_o,
  output bds_pkg::bds_drive_type      drive_o
);
  import bds_pkg::*;

  // ---------------- link domain (serial clock) ----------------
  // counter and load flags clear while the chip is deselected, so they
  // never need a clock edge after the frame has ended
  wire                     link_rst = rst_i | chip_select_n_i;
  logic [FRAME_BITS-1:0]   in_sr_r;
  logic [FRAME_BITS-1:0]   out_sr_r;
  logic [CNT_W-1:0]        bit_cnt_r;
  logic [CNT_W-1:0]        out_idx_r;
  logic                    loaded_r;
  logic                    bit_out_r;
  logic                    shown_r;
  logic [FRAME_BITS-1:0]   st0_snap_r;
  logic [FRAME_BITS-1:0]   st1_snap_r;

  wire frame_room = (bit_cnt_r < CNT_W'(FRAME_BITS));
  wire out_room   = (out_idx_r < CNT_W'(FRAME_BITS));

  // shift register keeps its content after the frame for the system side
  always_ff @(posedge spi_clk_i or posedge rst_i) begin // RL1
    if (rst_i) begin
      in_sr_r <= ST_RST;
    end else if (!chip_select_n_i && frame_room) begin
      in_sr_r <= {serial_in_i, in_sr_r[FRAME_BITS-1:1]}; // RL2 RL5
    end
  end

  always_ff @(posedge spi_clk_i or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_r <= '0; // RL7
    end else if (frame_room) begin
      bit_cnt_r <= bit_cnt_r + CNT_W'(1); // RL7
    end
  end

  always_ff @(posedge spi_clk_i or posedge link_rst) begin
    if (link_rst) begin
      loaded_r <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
    end
  end

  // bit 0 arrives on the very edge that loads, so it picks the word directly
  always_ff @(posedge spi_clk_i or posedge link_rst) begin
    if (link_rst) begin
      out_sr_r <= ST_RST;
    end else if (!loaded_r) begin
      out_sr_r <= serial_in_i ? st1_snap_r : st0_snap_r; // RL8 RL10
    end
  end

  always_ff @(negedge spi_clk_i or posedge link_rst) begin // RL1
    if (link_rst) begin
      shown_r <= 1'b0;
    end else if (loaded_r) begin
      shown_r <= 1'b1;
    end
  end

  // past the 16th bit the line reads low rather than repeating old data
  always_ff @(negedge spi_clk_i or posedge link_rst) begin
    if (link_rst) begin
      bit_out_r <= 1'b0;
    end else if (loaded_r) begin
      bit_out_r <= out_room ? out_sr_r[out_idx_r[3:0]] : 1'b0; // RL9 RL2
    end
  end

  always_ff @(negedge spi_clk_i or posedge link_rst) begin
    if (link_rst) begin
      out_idx_r <= '0;
    end else if (loaded_r && out_room) begin
      out_idx_r <= out_idx_r + CNT_W'(1);
    end
  end

  // ---------------- system domain: pin synchronisers ----------------
  logic [1:0]  cs_sync_r;
  logic [1:0]  clk_sync_r;
  logic [1:0]  din_sync_r;
  logic [1:0]  tm_sync_r;
  logic [1:0]  shown_sync_r;
  logic [1:0]  bit_sync_r;
  logic        cs_prev_r;
  logic        shown_q_r;
  bds_cond_type cond_m_r;
  bds_cond_type cond_s_r;

  // select chain resets high, its idle level, so reset leaves no false edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_sync_r <= 2'h3;
      cs_prev_r <= 1'b1;
    end else begin
      cs_sync_r <= {cs_sync_r[0], chip_select_n_i};
      cs_prev_r <= cs_sync_r[1];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_sync_r <= 2'h0;
      din_sync_r <= 2'h0;
      tm_sync_r  <= 2'h0;
    end else begin
      clk_sync_r <= {clk_sync_r[0], spi_clk_i};
      din_sync_r <= {din_sync_r[0], serial_in_i};
      tm_sync_r  <= {tm_sync_r[0], test_mode_i};
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shown_sync_r <= 2'h0;
      bit_sync_r   <= 2'h0;
      shown_q_r    <= 1'b0;
    end else begin
      shown_sync_r <= {shown_sync_r[0], shown_r};
      bit_sync_r   <= {bit_sync_r[0], bit_out_r};
      shown_q_r    <= shown_sync_r[1];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cond_m_r <= '0;
      cond_s_r <= '0;
    end else begin
      cond_m_r <= cond_i;
      cond_s_r <= cond_m_r;
    end
  end

  wire cs_n_s  = cs_sync_r[1];
  wire cs_rise = cs_n_s & ~cs_prev_r;
  wire cs_fall = ~cs_n_s & cs_prev_r;
  // extra stage on the shown flag lets the data bit settle first
  wire shown_s = shown_sync_r[1] & shown_q_r;

  // ---------------- control register ----------------
  logic [FRAME_BITS-1:0] ctrl_r;
  // link clock is stopped once chip select is high, so in_sr_r is static here
  wire clear_evt = cs_rise & in_sr_r[CTRL_CLR]; // RL16

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (cs_rise) begin
      ctrl_r <= in_sr_r; // RL6
    end
  end

  // ---------------- fault filters ----------------
  logic [10:0] ol_hit;
  logic [10:0] oc_hit;

  for (genvar i = 0; i < NUM_SW; i++) begin : g_filt
    logic [OL_CNT_W-1:0] ol_cnt_r;
    logic [OC_CNT_W-1:0] oc_cnt_r;
    assign ol_hit[i] = (ol_cnt_r == OL_CNT_W'(OL_FILT_CYC_P)); // RL20
    assign oc_hit[i] = (oc_cnt_r == OC_CNT_W'(OC_FILT_CYC)); // RL21
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        ol_cnt_r <= '0;
      end else if (!cond_s_r.ol[i]) begin
        ol_cnt_r <= '0;
      end else if (!ol_hit[i]) begin
        ol_cnt_r <= ol_cnt_r + OL_CNT_W'(1); // RL20
      end
    end
    // any gap restarts the count, so only a steady condition trips
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        oc_cnt_r <= '0;
      end else if (!cond_s_r.oc[i]) begin
        oc_cnt_r <= '0;
      end else if (!oc_hit[i]) begin
        oc_cnt_r <= oc_cnt_r + OC_CNT_W'(1); // RL21
      end
    end
  end

  // ---------------- status flags ----------------
  // a set in the clearing cycle wins, so no event is lost
  logic [10:0] st_oc_r;
  logic [10:0] st_ol_r;
  logic        st_tsd_r;
  logic        st_twarn_r;
  logic        st_uv_r;
  logic        st_ov_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_oc_r <= '0;
    end else begin
      st_oc_r <= oc_hit | (st_oc_r & {11{~clear_evt}}); // RL16 RL18
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ol_r <= '0;
    end else begin
      st_ol_r <= ol_hit | (st_ol_r & {11{~clear_evt}}); // RL16 RL20
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_tsd_r <= 1'b0;
    end else begin
      st_tsd_r <= cond_s_r.tsd | (st_tsd_r & ~clear_evt); // RL19
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_twarn_r <= 1'b0;
    end else begin
      st_twarn_r <= cond_s_r.twarn | (st_twarn_r & ~clear_evt);
    end
  end

  // supply flags always latch; the lockout bit only picks which one disables
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_uv_r <= 1'b0;
    end else begin
      st_uv_r <= cond_s_r.uv | (st_uv_r & ~clear_evt); // RL14
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ov_r <= 1'b0;
    end else begin
      st_ov_r <= cond_s_r.ov | (st_ov_r & ~clear_evt); // RL14
    end
  end

  // constant-one bit is left out, else the flag would never drop
  wire fault = (|st_oc_r) | (|st_ol_r) | st_tsd_r | st_twarn_r | st_uv_r | st_ov_r; // RL17

  wire [FRAME_BITS-1:0] st0_word = {1'b1, st_ov_r, st_uv_r, st_twarn_r, st_oc_r, fault}; // RL17
  wire [FRAME_BITS-1:0] st1_word = {1'b1, 2'b00, st_tsd_r, st_ol_r, fault}; // RL17

  // snapshot held for the whole frame, read by the link side at its first edge
  wire snap_open = cs_fall | cs_n_s;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st0_snap_r <= ST_RST;
    end else if (snap_open) begin
      st0_snap_r <= st0_word; // RL8
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st1_snap_r <= ST_RST;
    end else if (snap_open) begin
      st1_snap_r <= st1_word; // RL8
    end
  end

  // ---------------- serial output ----------------
  wire test_s = tm_sync_r[1];
  wire so_nxt = test_s  ? (clk_sync_r[1] | din_sync_r[1]) // RL25
              : shown_s ? bit_sync_r[1] // RL9
              :           fault; // RL4

  // registered so the pin never glitches while the select decode settles
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_out_oe_o <= 1'b0;
    end else begin
      serial_out_oe_o <= ~cs_n_s; // RL3
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_out_o <= 1'b0;
    end else begin
      serial_out_o <= cs_n_s ? 1'b0 : so_nxt; // RL3 RL4
    end
  end

  // ---------------- output stage control ----------------
  wire [10:0] sw_req    = ctrl_r[CTRL_SW_HI:CTRL_SW_LO]; // RL11 RL12
  wire        standby   = ~ctrl_r[CTRL_MON_HI] & ~ctrl_r[CTRL_MON_LO]; // RL13
  wire        lockout   = ctrl_r[CTRL_LOCKOUT];
  wire        vs_latch  = st_uv_r | st_ov_r;
  wire        vs_live   = cond_s_r.uv | cond_s_r.ov;
  wire        vs_off    = lockout ? vs_latch : vs_live; // RL14 RL15
  wire        all_off   = standby | st_tsd_r | vs_off; // RL19
  wire        test_a    = ctrl_r[CTRL_TA_LO] & ctrl_r[CTRL_TA_HI]; // RL22
  wire        test_b    = ctrl_r[CTRL_TB_LO] & ctrl_r[CTRL_TB_HI]; // RL22
  wire [10:0] sw_ok     = sw_req & ~st_oc_r & ~oc_hit; // RL18 RL21
  logic [10:0] sw_safe;

  // low and high side of one leg never on together
  for (genvar p = 0; p < 5; p++) begin : g_leg
    wire both = sw_ok[2*p] & sw_ok[2*p+1];
    assign sw_safe[2*p]   = sw_ok[2*p] & ~both; // RL24
    assign sw_safe[2*p+1] = sw_ok[2*p+1] & ~both; // RL24
  end
  assign sw_safe[10] = sw_ok[10];

  wire [10:0] sw_on     = sw_safe & {11{~all_off}};
  // split stages: a-pair keeps only a, b-pair only b, both pairs neither
  wire [10:0] stage_a_n = sw_on & ~(SPLIT_MASK & {11{test_b}}); // RL22 RL23
  wire [10:0] stage_b_n = sw_on & SPLIT_MASK & {11{~test_a}}; // RL22 RL23

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_o <= '{stage_a: '0, stage_b: '0, standby: 1'b1, mon_sel: 2'h0};
    end else begin
      drive_o.stage_a <= stage_a_n;
      drive_o.stage_b <= stage_b_n;
      drive_o.standby <= standby; // RL13
      drive_o.mon_sel <= ctrl_r[CTRL_MON_HI:CTRL_MON_LO]; // RL13
    end
  end

endmodule

// *** verif/bds_host_model.sv ***
// Purpose: microcontroller end of the serial link, bit-banged pins
// Assumes: link clock period 125 ns, running only inside frames
// Notes:   reads serial out on the rising link clock edge like the device
module bds_host_model (
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end
  // raw pin access, used for the test mode path
  task automatic pins(input logic cs, input logic ck, input logic di);
    {cs_n_o, sclk_o, sdi_o} = {cs, ck, di};
  endtask
  task automatic frame(input logic [31:0] w, input int n, input logic cpol,
                       output logic flt, output logic [15:0] rd);
    rd = 16'h0000;
    sclk_o = cpol;
    // odd offset keeps select edges off the system clock edges
    #103 cs_n_o = 1'b0;
    #62.5 flt = sdo_i;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      sdi_o  = w[i];
      #62.5 sclk_o = 1'b1;
      if (i > 0 && i < 17) rd[i-1] = sdo_i;
      #62.5;
    end
    sclk_o = 1'b0;
    #62.5;
    if (n == 16) rd[15] = sdo_i;
    cs_n_o = 1'b1;
    sdi_o  = ~sdi_o;
    sclk_o = cpol;
    #100;
  endtask
endmodule

// *** verif/bds_serial_ctrl_props.sv ***
// Purpose: port-level checks of the bridge driver serial control block
// Assumes: one system clock domain, asynchronous active-high reset
// Notes:   cycle margins cover the two-flop synchronisers on every input
module bds_serial_ctrl_props (
  input wire logic                   sys_clk_i,
  input wire logic                   rst_i,
  input wire logic                   spi_clk_i,
  input wire logic                   chip_select_n_i,
  input wire logic                   serial_in_i,
  input wire logic                   test_mode_i,
  input wire bds_pkg::bds_cond_type  cond_i,
  input wire logic                   serial_out_o,
  input wire logic                   serial_out_oe_o,
  input wire bds_pkg::bds_drive_type drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import bds_pkg::*;
  logic [10:0] on_w;
  logic [4:0]  shoot_w;
  assign on_w    = drive_o.stage_a | drive_o.stage_b;
  assign shoot_w = {on_w[9], on_w[7], on_w[5], on_w[3], on_w[1]}
                 & {on_w[8], on_w[6], on_w[4], on_w[2], on_w[0]};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  oe_off_a: assert property (chip_select_n_i [*6] |-> !serial_out_oe_o)
    else $error("serial out driven while deselected");
  oe_on_a: assert property ($fell(chip_select_n_i) ##1 !chip_select_n_i [*5]
    |-> serial_out_oe_o) else $error("serial out not driven in frame");
  standby_off_a: assert property (drive_o.standby == (drive_o.mon_sel == 2'h0)
    && (!drive_o.standby || on_w == 11'h000)) else $error("standby mismatch");
  no_shoot_a: assert property (shoot_w == 5'h00)
    else $error("both switches of one leg on");
  split_only_a: assert property ((drive_o.stage_b & ~SPLIT_MASK) == 11'h000)
    else $error("second stage on a non-split switch");
  thermal_off_a: assert property (cond_i.tsd [*8] |-> on_w == 11'h000)
    else $error("outputs on during thermal shutdown");
  supply_off_a: assert property (cond_i.ov [*8] |-> on_w == 11'h000)
    else $error("outputs on during supply fault");
  test_or_a: assert property ((test_mode_i && !chip_select_n_i
    && $stable({spi_clk_i, serial_in_i})) [*6] |-> serial_out_o == (spi_clk_i | serial_in_i))
    else $error("test path not the or of clock and data");
  out_hold_a: assert property ((!chip_select_n_i && !test_mode_i
    && $stable({chip_select_n_i, spi_clk_i})) [*6] |=> $stable(serial_out_o))
    else $error("serial out moved without a clock edge");
  reset_state_a: assert property ($fell(rst_i) |-> drive_o.standby
    && !serial_out_oe_o && on_w == 11'h000) else $error("bad state after reset");
endmodule

bind bds_serial_ctrl bds_serial_ctrl_props bds_serial_ctrl_props_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_clk_i(spi_clk_i),
  .chip_select_n_i(chip_select_n_i), .serial_in_i(serial_in_i),
  .test_mode_i(test_mode_i), .cond_i(cond_i), .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o), .drive_o(drive_o));

// *** verif/bds_serial_ctrl_tb.sv ***
// Purpose: self-checking bench for the bridge driver serial control block
// Assumes: open-load filter shortened to 20 cycles
// Notes:   random control words from a fixed seed plus corner words
`define CHECK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module bds_serial_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bds_pkg::*;
  logic          sys_clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          test_mode_i = 1'b0;
  logic          cs_n, sclk, sdi, sout, soe, flt;
  wire           sdo_w;
  bds_cond_type  cond_i = '0;
  bds_drive_type drive_o;
  logic [15:0]   rd;
  logic [31:0]   w;
  logic [15:0]   corner [4] = '{16'h2064, 16'h2184, 16'h21E4, 16'h3FFE};
  int            fails = 0;
  int            samples_checked = 0;
  int            seed = 39;
  always #5 sys_clk_i = ~sys_clk_i;
  // nobody else drives serial out, so an undriven pin reads as z
  assign sdo_w = soe ? sout : 1'bz;
  bds_serial_ctrl #(.OL_FILT_CYC_P(20)) bds_serial_ctrl_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_clk_i(sclk), .chip_select_n_i(cs_n),
    .serial_in_i(sdi), .test_mode_i(test_mode_i), .cond_i(cond_i),
    .serial_out_o(sout), .serial_out_oe_o(soe), .drive_o(drive_o));
  bds_host_model bds_host_model_i (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo_w));
  function automatic bds_drive_type exp_drv(input logic [15:0] c, input logic off);
    logic [10:0]   r;
    bds_drive_type d;
    r = c[11:1];
    for (int k = 0; k < 10; k += 2) if (r[k] && r[k+1]) r[k+1 -: 2] = 2'h0;
    if (off || c[13:12] == 2'h0) r = '0;
    d.stage_a = (c[7] && c[8]) ? r & ~SPLIT_MASK : r;
    d.stage_b = (c[5] && c[6]) ? 11'h000 : r & SPLIT_MASK;
    d.standby = (c[13:12] == 2'h0);
    d.mon_sel = c[13:12];
    return d;
  endfunction
  task automatic xfer(input logic [31:0] v, input int n, input logic [15:0] est,
                      input logic ef, input logic off);
    bds_host_model_i.frame(v, n, 1'($random(seed)), flt, rd);
    `CHECK(flt, ef)
    `CHECK(rd, est)
    repeat (7) @(negedge sys_clk_i);
    `CHECK(drive_o, exp_drv(v[15:0], off))
  endtask
  task automatic apply(input bds_cond_type c, input int cyc);
    @(posedge sys_clk_i) cond_i <= c;
    repeat (cyc) @(posedge sys_clk_i);
    cond_i <= '0;
    repeat (5) @(negedge sys_clk_i);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    `CHECK(drive_o, exp_drv(16'h0000, 1'b0))
    `CHECK(soe, 1'b0)
    for (int i = 0; i < 24; i++) begin
      w = (i < 4) ? {16'h0000, corner[i]} : $random(seed);
      xfer(w, 16 + (i % 3), 16'h8000, 1'b0, 1'b0);
    end
    apply(26'h80_0000, 10);
    xfer(32'h3003, 16, 16'h9001, 1'b1, 1'b1);
    xfer(32'hB002, 16, 16'h8001, 1'b1, 1'b0);
    xfer(32'h3002, 16, 16'h8000, 1'b0, 1'b0);
    apply(26'h1, 500);
    xfer(32'h3002, 16, 16'h8000, 1'b0, 1'b0);
    apply(26'h1, 1100);
    xfer(32'h3002, 16, 16'h8003, 1'b1, 1'b1);
    xfer(32'hB002, 16, 16'h8003, 1'b1, 1'b0);
    apply(26'h2000, 15);
    xfer(32'h3003, 16, 16'h8000, 1'b0, 1'b0);
    apply(26'h2000, 30);
    xfer(32'hB003, 16, 16'h8009, 1'b1, 1'b0);
    apply(26'h100_0000, 20);
    `CHECK(drive_o.stage_a, 11'h001)
    xfer(32'hF002, 16, 16'hC001, 1'b1, 1'b0);
    apply(26'h100_0000, 20);
    `CHECK(drive_o.stage_a, 11'h000)
    xfer(32'hB002, 16, 16'hC001, 1'b1, 1'b0);
    @(posedge sys_clk_i) test_mode_i <= 1'b1;
    @(negedge sys_clk_i);
    for (int k = 0; k < 4; k++) begin
      bds_host_model_i.pins(1'b0, k[1], k[0]);
      repeat (8) @(negedge sys_clk_i);
      `CHECK(sout, k[1] | k[0])
    end
    end_of_test;
  end
  // 34 frames of 2.3 us plus filter waits; a wide margin on top
  initial begin
    #400_000;
    fails++;
    end_of_test;
  end
endmodule
